/* verilog/lise_cfg.svh */
// register offsets, field positions and reset values for the link interrupt block
`ifndef LISE_CFG_SVH
`define LISE_CFG_SVH
`define LISE_ADDR_MASTER_EN   12'h433
`define LISE_ADDR_TC_OVF_EN   12'h434
`define LISE_ADDR_STATUS_LO   12'h435
`define LISE_ADDR_STATUS_HI   12'h444
`define LISE_ADDR_LINK_EN_LO  12'h445
`define LISE_ADDR_LINK_EN_HI  12'h454
`define LISE_ADDR_MASTER_ST   12'h455
`define LISE_BIT_SYNC_END     11
`define LISE_BIT_FRAME_END    10
`define LISE_BIT_DELIN_END    9
`define LISE_BIT_GRP_OVF      8
`define LISE_BIT_CPC_DONE     7
`define LISE_BIT_CPC_RAM_OVF  6
`define LISE_BIT_CPC_CHANGE   5
`define LISE_BIT_CPC_VIOL     4
`define LISE_BIT_SYNC_LOST    3
`define LISE_BIT_FRAME_LOST   2
`define LISE_BIT_DELIN_LOST   1
`define LISE_BIT_CNT_OVF      0
`define LISE_STATUS_USED_MASK 16'h0fff
`define LISE_W0C_MASK         12'hefe
`define LISE_RST_16           16'h0000
`endif

/* verilog/lise_pkg.sv */
// types shared by the link interrupt block
package lise_pkg;
  typedef logic [15:0] lise_word_type;
  typedef logic [11:0] lise_addr_type;
  typedef logic [11:0] lise_stat_type;
endpackage

/* verilog/lise_link_irq.sv */
// per-link interrupt status, enables and the active-low interrupt pin
// Notes on behaviour
// - master enable holds one enable per link
// - disabled link never affects interrupt pin
// - tc overflow enable gates link counter overflow
// - status bits 15:12 read zero, ignore writes
// - bit 11 sets when delay sync returns
// - bit 10 sets when frame loss ends
// - bit 9 sets when delineation loss ends
// - bit 8 is live group overflow summary
// - group summary only in link 0
// - bit 7 sets on cell done, frame pulse
// - bit 7 write-zero clears, link 0 only
// - bit 6 sets on pre-processing ram overflow
// - bit 5 sets on changed control cell
// - per-link enable gates each status bit
// - master status is live, read-only
// - master enable change acts on pin immediately
`timescale 1ns/1ps
`include "lise_cfg.svh"
module lise_link_irq (
  // clock and reset
  input  wire logic             I_SYS_CLK,
  input  wire logic             I_RST,
  // host register port, synchronous to the system clock
  input  wire lise_pkg::lise_addr_type I_ADDR,
  input  wire logic             I_WR,
  input  wire logic             I_RD,
  input  wire lise_pkg::lise_word_type I_WDATA,
  output logic [15:0]           O_RDATA,
  output logic                  O_RD_HIT,
  // per-link event pulses and levels from the link logic
  input  wire logic [15:0]      I_DELAY_SYNC_LOST,
  input  wire logic [15:0]      I_FRAME_LOST,
  input  wire logic [15:0]      I_CELL_DELINEATION_LOST,
  input  wire logic [15:0]      I_CPC_RAM_OVF,
  input  wire logic [15:0]      I_CPC_CHANGE,
  input  wire logic [15:0]      I_CPC_VIOLATION,
  input  wire logic [15:0]      I_TC_OVF_REQ,
  // group-level sources, reported in link 0 only
  input  wire logic [7:0]       I_GROUP_OVF_STATUS,
  input  wire logic             I_CPC_TX_DONE,
  input  wire logic             I_FRAME_PULSE,
  // interrupt pin toward the host, active low
  output logic                  O_IRQ_N
);
  import lise_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  lise_word_type master_en_r, master_en_nxt;
  lise_word_type tc_en_r,     tc_en_nxt;
  lise_stat_type stat_r   [16];
  lise_stat_type stat_nxt [16];
  lise_stat_type link_en_r   [16];
  lise_stat_type link_en_nxt [16];
  // previous defect levels, for the end-of-defect edges
  logic [15:0] sync_d_r, frame_d_r, delin_d_r;
  logic [15:0] rdata_r, rdata_nxt;
  logic        rd_hit_r, rd_hit_nxt;
  // live request per link and the group summary
  logic [15:0] link_req;
  logic        grp_ovf;

  // ------------------------------------------------------------
  // address decode helpers
  // ------------------------------------------------------------
  // true when the address falls inside one sixteen-register block
  function automatic logic in_block(input lise_addr_type a, input lise_addr_type lo,
                                    input lise_addr_type hi);
    in_block = (a >= lo) && (a <= hi);
  endfunction

  // link index inside a block; only the low four bits are kept on purpose
  function automatic logic [3:0] idx(input lise_addr_type a, input lise_addr_type lo);
    lise_addr_type d;
    d   = a - lo;
    idx = d[3:0];
  endfunction

  // group overflow summary is a live level, never latched
  assign grp_ovf = |I_GROUP_OVF_STATUS;

  // ------------------------------------------------------------
  // next-state: enables and latched status
  // ------------------------------------------------------------
  always_comb begin
    lise_stat_type ev;
    lise_stat_type clr;
    ev           = '0;
    clr          = '0;
    master_en_nxt = master_en_r;
    tc_en_nxt     = tc_en_r;
    // register write decode; writes to the master status and to unmapped
    // addresses fall through every test and change nothing
    if (I_WR && I_ADDR == `LISE_ADDR_MASTER_EN) begin
      master_en_nxt = I_WDATA;
    end
    // host guarantees the receive line clock runs here
    if (I_WR && I_ADDR == `LISE_ADDR_TC_OVF_EN) begin
      tc_en_nxt = I_WDATA;
    end
    for (int i = 0; i < 16; i++) begin
      link_en_nxt[i] = link_en_r[i];
      if (I_WR && I_ADDR == `LISE_ADDR_LINK_EN_LO + 12'(i)) begin
        link_en_nxt[i] = I_WDATA[11:0];
      end
      // event detection: end of each defect is its falling edge
      // a defect level still high keeps re-setting bits 3..1, so a clear
      // only sticks once the link has recovered
      ev = '0;
      ev[`LISE_BIT_SYNC_END]    = sync_d_r[i] & ~I_DELAY_SYNC_LOST[i];
      ev[`LISE_BIT_FRAME_END]   = frame_d_r[i] & ~I_FRAME_LOST[i];
      ev[`LISE_BIT_DELIN_END]   = delin_d_r[i] & ~I_CELL_DELINEATION_LOST[i];
      ev[`LISE_BIT_CPC_RAM_OVF] = I_CPC_RAM_OVF[i];
      ev[`LISE_BIT_CPC_CHANGE]  = I_CPC_CHANGE[i];
      ev[`LISE_BIT_CPC_VIOL]    = I_CPC_VIOLATION[i];
      ev[`LISE_BIT_SYNC_LOST]   = I_DELAY_SYNC_LOST[i];
      ev[`LISE_BIT_FRAME_LOST]  = I_FRAME_LOST[i];
      ev[`LISE_BIT_DELIN_LOST]  = I_CELL_DELINEATION_LOST[i];
      if (i == 0) begin
        ev[`LISE_BIT_CPC_DONE] = I_CPC_TX_DONE | I_FRAME_PULSE;
      end
      // write zero clears; writing one keeps the bit
      clr = '0;
      if (I_WR && I_ADDR == `LISE_ADDR_STATUS_LO + 12'(i)) begin
        clr = ~I_WDATA[11:0] & `LISE_W0C_MASK;
      end
      // set wins over clear so a coincident event is not lost
      stat_nxt[i] = ((stat_r[i] & ~clr) | ev) & `LISE_W0C_MASK;
    end
  end

  // ------------------------------------------------------------
  // master status and read path
  // ------------------------------------------------------------
  // master status: live per-link request, not latched
  // tc enable gates only the request; a status read shows the raw level
  always_comb begin
    lise_stat_type view;
    view = '0;
    for (int i = 0; i < 16; i++) begin
      view = stat_r[i];
      view[`LISE_BIT_CNT_OVF] = I_TC_OVF_REQ[i] & tc_en_r[i];
      if (i == 0) begin
        view[`LISE_BIT_GRP_OVF] = grp_ovf;
      end
      link_req[i] = |(view & link_en_r[i]);
    end
  end

  // read path: registered data
  // a read in the same cycle as a write returns the old value
  // bits 0 and 8 are live levels, so a status read samples them at the strobe
  always_comb begin
    rdata_nxt  = rdata_r;
    rd_hit_nxt = 1'b0;
    if (I_RD) begin
      rd_hit_nxt = 1'b1;
      rdata_nxt  = '0;
      if (I_ADDR == `LISE_ADDR_MASTER_EN) begin
        rdata_nxt = master_en_r;
      end else if (I_ADDR == `LISE_ADDR_TC_OVF_EN) begin
        rdata_nxt = tc_en_r;
      end else if (I_ADDR == `LISE_ADDR_MASTER_ST) begin
        rdata_nxt = link_req;
      end else if (in_block(I_ADDR, `LISE_ADDR_STATUS_LO, `LISE_ADDR_STATUS_HI)) begin
        rdata_nxt = {4'h0, stat_r[idx(I_ADDR, `LISE_ADDR_STATUS_LO)]};
        rdata_nxt[`LISE_BIT_CNT_OVF] = I_TC_OVF_REQ[idx(I_ADDR, `LISE_ADDR_STATUS_LO)];
        if (idx(I_ADDR, `LISE_ADDR_STATUS_LO) == 4'h0) begin
          rdata_nxt[`LISE_BIT_GRP_OVF] = grp_ovf;
        end
      end else if (in_block(I_ADDR, `LISE_ADDR_LINK_EN_LO, `LISE_ADDR_LINK_EN_HI)) begin
        rdata_nxt = {4'h0, link_en_r[idx(I_ADDR, `LISE_ADDR_LINK_EN_LO)]};
      end else begin
        rd_hit_nxt = 1'b0; // unmapped reads return zero
      end
    end
  end

  // ------------------------------------------------------------
  // registers only
  // ------------------------------------------------------------
  // reset loads constants only; no input reaches the reset branch
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      master_en_r <= `LISE_RST_16;
      tc_en_r     <= `LISE_RST_16;
      sync_d_r    <= '0;
      frame_d_r   <= '0;
      delin_d_r   <= '0;
      rdata_r     <= `LISE_RST_16;
      rd_hit_r    <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        stat_r[i]    <= '0;
        link_en_r[i] <= '0;
      end
    end else begin
      master_en_r <= master_en_nxt;
      tc_en_r     <= tc_en_nxt;
      sync_d_r    <= I_DELAY_SYNC_LOST;
      frame_d_r   <= I_FRAME_LOST;
      delin_d_r   <= I_CELL_DELINEATION_LOST;
      rdata_r     <= rdata_nxt;
      rd_hit_r    <= rd_hit_nxt;
      for (int i = 0; i < 16; i++) begin
        stat_r[i]    <= stat_nxt[i];
        link_en_r[i] <= link_en_nxt[i];
      end
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // pin is combinational so an enable change acts at once
  assign O_IRQ_N  = ~|(link_req & master_en_r);
  // read data and hit come straight from flip-flops
  assign O_RDATA  = rdata_r;
  assign O_RD_HIT = rd_hit_r;
endmodule

/* dv/lise_link_irq_properties.sv */
// port-level assertions for the link interrupt block
`timescale 1ns/1ps
module lise_link_irq_properties (
  // clock and reset
  input wire logic                    I_SYS_CLK,
  input wire logic                    I_RST,
  // host register port
  input wire lise_pkg::lise_addr_type I_ADDR,
  input wire logic                    I_WR,
  input wire logic                    I_RD,
  input wire lise_pkg::lise_word_type I_WDATA,
  input wire logic [15:0]             O_RDATA,
  input wire logic                    O_RD_HIT,
  // group sources and the interrupt pin
  input wire logic [7:0]              I_GROUP_OVF_STATUS,
  input wire logic                    O_IRQ_N
);
  import lise_pkg::*;
  logic [15:0] men_r; // shadow of the master enable, rebuilt from host writes
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // shadow register so pin checks need no view inside the block
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      men_r <= 16'h0000;
    end else if (I_WR && I_ADDR == 12'h433) begin
      men_r <= I_WDATA;
    end
  end
  rd_hit_a: assert property (
    I_RD && I_ADDR inside {[12'h433:12'h455]} |=> O_RD_HIT)
    else $error("mapped read gave no hit");
  rd_miss_a: assert property (
    I_RD && I_ADDR > 12'h455 |=> !O_RD_HIT && O_RDATA == 16'h0000)
    else $error("unmapped read not empty");
  rd_idle_a: assert property (
    !I_RD |=> !O_RD_HIT)
    else $error("hit without a read");
  stat_top_a: assert property (
    I_RD && I_ADDR inside {[12'h435:12'h444]} |=> O_RDATA[15:12] == 4'h0)
    else $error("status top bits not zero");
  grp_only0_a: assert property (
    I_RD && I_ADDR inside {[12'h436:12'h444]} |=> O_RDATA[8:7] == 2'h0)
    else $error("link 0 only bits set elsewhere");
  grp_live_a: assert property (
    I_RD && I_ADDR == 12'h435 |=> O_RDATA[8] == ($past(I_GROUP_OVF_STATUS) != 8'h00))
    else $error("group summary wrong");
  men_echo_a: assert property (
    I_RD && I_ADDR == 12'h433 |=> O_RDATA == $past(men_r))
    else $error("master enable readback wrong");
  men_off_a: assert property (
    men_r == 16'h0000 |-> O_IRQ_N)
    else $error("pin low with all links masked");
  irq_pin_a: assert property (
    I_RD && I_ADDR == 12'h455 |=> $past(O_IRQ_N) == !(|(O_RDATA & $past(men_r))))
    else $error("pin disagrees with master status");
endmodule
bind lise_link_irq lise_link_irq_properties i_lise_link_irq_properties (
  .I_SYS_CLK          (I_SYS_CLK),
  .I_RST              (I_RST),
  .I_ADDR             (I_ADDR),
  .I_WR               (I_WR),
  .I_RD               (I_RD),
  .I_WDATA            (I_WDATA),
  .O_RDATA            (O_RDATA),
  .O_RD_HIT           (O_RD_HIT),
  .I_GROUP_OVF_STATUS (I_GROUP_OVF_STATUS),
  .O_IRQ_N            (O_IRQ_N)
);

/* dv/lise_host_bfm.sv */
// host model: one register access per call, strobes raised at a rising edge
`timescale 1ns/1ps
module lise_host_bfm (
  // clock and read data from the block
  input  wire logic               i_clk,
  input  wire logic [15:0]        i_rdata,
  // register strobes toward the block
  output lise_pkg::lise_addr_type o_addr,
  output lise_pkg::lise_word_type o_wdata,
  output logic                    o_wr,
  output logic                    o_rd
);
  import lise_pkg::*;
  // idle bus before the first edge
  initial begin
    {o_addr, o_wdata, o_wr, o_rd} = '0;
  end
  // released lines show the inverse so stale values are never trusted
  // the tc enable is only touched while the receive line clock runs
  task automatic wr_reg(input lise_addr_type a, input lise_word_type d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask
  // read: strobe taken at one edge, registered answer settles just after it
  task automatic rd_reg(input lise_addr_type a, output lise_word_type d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule

/* dv/tb.sv */
// self-checking bench for the link interrupt block
`timescale 1ns/1ps
module tb;
  import lise_pkg::*;
  logic clk = 0, rst = 1, wr, rd, tx_done = 0, fpulse = 0;
  lise_addr_type addr;
  lise_word_type wdata, rdata, d;
  logic [15:0] sync_l = 0, frame_l = 0, delin_l = 0, ram_ovf = 0, chg = 0, viol = 0, tc_req = 0;
  logic [7:0]  grp = 0;
  logic        hit, irq_n;
  int miscompares = 0, checks_done = 0, cyc = 0;
  logic [43:0] rows [6] = '{{12'h433, 16'hffff, 16'hffff}, {12'h434, 16'ha5a5, 16'ha5a5},
    {12'h445, 16'hffff, 16'h0fff}, {12'h455, 16'hffff, 16'h0000}, {12'h435, 16'hffff, 16'h0000},
    {12'h456, 16'hffff, 16'h0000}};
  always #50 clk = ~clk;
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin miscompares++; test_done(); end
  end
  lise_host_bfm i_lise_host_bfm (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  lise_link_irq i_lise_link_irq (.I_SYS_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
    .I_WDATA(wdata), .O_RDATA(rdata), .O_RD_HIT(hit), .I_DELAY_SYNC_LOST(sync_l),
    .I_FRAME_LOST(frame_l), .I_CELL_DELINEATION_LOST(delin_l), .I_CPC_RAM_OVF(ram_ovf),
    .I_CPC_CHANGE(chg), .I_CPC_VIOLATION(viol), .I_TC_OVF_REQ(tc_req),
    .I_GROUP_OVF_STATUS(grp), .I_CPC_TX_DONE(tx_done), .I_FRAME_PULSE(fpulse), .O_IRQ_N(irq_n));
  task automatic chk(input lise_word_type got, input lise_word_type exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input lise_addr_type a, input lise_word_type exp);
    i_lise_host_bfm.rd_reg(a, d);
    chk(d, exp);
  endtask
  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 chk(irq_n, 16'h0001);
    rc(12'h433, 16'h0000);
    // ordinary accesses: write each row, read it back
    foreach (rows[i]) begin
      i_lise_host_bfm.wr_reg(rows[i][43:32], rows[i][31:16]);
      rc(rows[i][43:32], rows[i][15:0]);
    end
    // defects rise on link 0 together with the done pulse and fall one cycle after it
    @(posedge clk); {sync_l[0], frame_l[0], delin_l[0], ram_ovf[0], tx_done} <= '1;
    @(posedge clk); {ram_ovf[0], tx_done} <= '0;
    @(posedge clk); {sync_l[0], frame_l[0], delin_l[0]} <= '0;
    repeat (2) @(posedge clk);
    rc(12'h435, 16'h0ece);
    rc(12'h455, 16'h0001);
    rc(12'h436, 16'h0000);
    #1 chk(irq_n, 16'h0000);
    i_lise_host_bfm.wr_reg(12'h435, 16'hfb7f);
    rc(12'h435, 16'h0a4e);
    // a change event lands on the same edge as a clearing write
    fork
      i_lise_host_bfm.wr_reg(12'h435, 16'h0000);
      begin @(posedge clk); chg[0] <= 1'b1; @(posedge clk); chg[0] <= 1'b0; end
    join
    rc(12'h435, 16'h0020);
    i_lise_host_bfm.wr_reg(12'h435, 16'h0000);
    grp <= 8'h04;
    rc(12'h435, 16'h0100);
    rc(12'h436, 16'h0000);
    i_lise_host_bfm.wr_reg(12'h433, 16'h0000);
    #1 chk(irq_n, 16'h0001);
    i_lise_host_bfm.wr_reg(12'h433, 16'h0001);
    #1 chk(irq_n, 16'h0000);
    @(posedge clk) grp <= 8'h00;
    // counter overflow on link 1 only reaches the pin through the tc enable
    i_lise_host_bfm.wr_reg(12'h446, 16'h0001);
    i_lise_host_bfm.wr_reg(12'h433, 16'h0002);
    i_lise_host_bfm.wr_reg(12'h434, 16'h0000);
    tc_req <= 16'h0002;
    repeat (2) @(posedge clk);
    #1 chk(irq_n, 16'h0001);
    i_lise_host_bfm.wr_reg(12'h434, 16'h0002);
    #1 chk(irq_n, 16'h0000);
    // a lone frame pulse sets bit 7 of link 0 only; a violation sets bit 4
    @(posedge clk) {fpulse, viol[0]} <= '1;
    @(posedge clk) {fpulse, viol[0]} <= '0;
    rc(12'h435, 16'h0090);
    rc(12'h436, 16'h0001);
    // a mid-run reset empties every register and frees the pin
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(irq_n, 16'h0001);
    @(posedge clk) rst <= 1'b0;
    rc(12'h435, 16'h0000);
    rc(12'h433, 16'h0000);
    test_done();
  end
endmodule
